// *** src/lane_health_pkg.sv ***
package lane_health_pkg;

   // Register offsets on the configuration port
   localparam logic [11:0] LANE7_LINK_HEALTH_ADDR = 12'h4b7;
   localparam logic [11:0] LINK_IRQ_ENABLE_A_ADDR = 12'h4b8;

   // Health register field positions
   localparam int DISPARITY_BIT      = 7;
   localparam int INVALID_CODE_BIT   = 6;
   localparam int UNEXPECTED_K_BIT   = 5;
   localparam int DESKEW_BIT         = 4;
   localparam int INITIAL_SYNC_BIT   = 3;
   localparam int CHECKSUM_BIT       = 2;
   localparam int FRAME_SYNC_BIT     = 1;
   localparam int CODE_GROUP_BIT     = 0;

   // Writable enable bits in the first interrupt-enable register
   localparam logic [7:0] IRQ_ENABLE_A_WMASK = 8'hf8;

   // Reset values
   localparam logic [7:0] LANE7_LINK_HEALTH_RESET = 8'h00;
   localparam logic [7:0] LINK_IRQ_ENABLE_A_RESET = 8'h00;
   localparam logic [7:0] ERROR_COUNT_RESET       = 8'h00;

   // Synchroniser depth for lane-state inputs from the link receiver
   localparam int SYNC_STAGES = 3;

   // Error counts coming from the lane receiver
   typedef struct packed {
      logic [7:0] disparity;
      logic [7:0] invalid_code;
      logic [7:0] unexpected_control;
   } lane_error_counts_t;

   // Lane state levels from the link receiver
   typedef struct packed {
      logic deskew_ok;
      logic initial_sync_ok;
      logic checksum_ok;
      logic frame_sync_ok;
      logic code_group_sync_ok;
   } lane_states_t;

   // Configuration port access
   typedef struct packed {
      logic        rd_en;
      logic        wr_en;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } cfg_req_t;

endpackage

// *** src/lane_state_sync.sv ***
`timescale 1ns/1ps
module lane_state_sync
   import lane_health_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Asynchronous levels in, settled levels out
   input  wire lane_states_t raw_in,
   output lane_states_t      settled_out
);

   typedef struct packed {
      lane_states_t [SYNC_STAGES-1:0] stage;
      lane_states_t                   settled;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      state_next.stage[0] = raw_in;
      state_next.stage[1] = state_reg.stage[0];
      state_next.stage[2] = state_reg.stage[1];
      // A change counts only once the second and third stages agree
      if (state_reg.stage[1] == state_reg.stage[2])
      begin
         state_next.settled = state_reg.stage[2];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign settled_out = state_reg.settled;

endmodule

// *** src/serial_lane_status_irq_enable.sv ***
// Notes on behaviour
// - Bit 7 of the lane-7 health register is 1 while the disparity error count is at or above the threshold.
// - Bit 6 is 1 while the not-in-table symbol count is at or above the threshold, else 0.
// - Bit 5 is 1 while the unexpected control character count is at or above the threshold, else 0.
// - Bit 4 shows lane-7 deskew, 1 when achieved and 0 when failed.
// - Bit 2 shows whether the computed lane-7 checksum is correct.
// - Bit 1 shows lane-7 frame sync, 1 achieved and 0 lost.
// - Bit 0 shows lane-7 code group sync and stays valid whatever the skip-alignment setting.
// - Bit 3 shows initial lane sync, and software ignores bits 4 to 1 while alignment is skipped.
// - Enable bits 7 and 6 gate disparity and not-in-table interrupts and reset to 0.
// - Enable bits 5, 4 and 3 gate unexpected-K, deskew and initial-sync interrupts and reset to 0.
`timescale 1ns/1ps
module serial_lane_status_irq_enable
   import lane_health_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // Configuration port
   input  wire cfg_req_t           cfg_req,
   output logic [7:0]              cfg_rdata,
   output logic                    cfg_rvalid,
   // Threshold and alignment mode from the link setup
   input  wire logic [7:0]         error_threshold,
   input  wire logic               skip_alignment_sequence,
   // Lane-7 receiver inputs
   input  wire lane_error_counts_t lane7_counts,
   input  wire lane_states_t       lane7_states_raw,
   // Interrupt requests per gated event
   output logic [4:0]              link_event_irq,
   // Current register contents
   output logic [7:0]              lane7_link_health,
   output logic [7:0]              link_irq_enable_a
);

   typedef struct packed {
      logic [7:0] health;
      logic [7:0] irq_enable;
      logic [7:0] rdata;
      logic       rvalid;
      logic [4:0] irq;
   } bank_state_t;

   bank_state_t  state_reg;
   bank_state_t  state_next;
   lane_states_t lane7_states;
   logic [4:0]   events;

   // Counts share the block clock, so only the state levels need synchronising
   lane_state_sync u_state_sync (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .raw_in      (lane7_states_raw),
      .settled_out (lane7_states)
   );

   always_comb
   begin
      state_next = state_reg;

      state_next.health[DISPARITY_BIT] = (lane7_counts.disparity >= error_threshold);
      state_next.health[INVALID_CODE_BIT] = (lane7_counts.invalid_code >= error_threshold);
      state_next.health[UNEXPECTED_K_BIT] = (lane7_counts.unexpected_control >= error_threshold);
      state_next.health[DESKEW_BIT] = lane7_states.deskew_ok;
      state_next.health[INITIAL_SYNC_BIT] = lane7_states.initial_sync_ok;
      state_next.health[CHECKSUM_BIT] = lane7_states.checksum_ok;
      state_next.health[FRAME_SYNC_BIT] = lane7_states.frame_sync_ok;
      state_next.health[CODE_GROUP_BIT] = lane7_states.code_group_sync_ok;

      if (cfg_req.wr_en && cfg_req.addr == LINK_IRQ_ENABLE_A_ADDR)
      begin
         state_next.irq_enable = cfg_req.wdata & IRQ_ENABLE_A_WMASK;
      end

      // Reads return the contents as stored before this cycle's write
      state_next.rvalid = cfg_req.rd_en;
      state_next.rdata  = 8'h00;
      if (cfg_req.rd_en)
      begin
         unique case (cfg_req.addr)
            LANE7_LINK_HEALTH_ADDR: state_next.rdata = state_reg.health;
            LINK_IRQ_ENABLE_A_ADDR: state_next.rdata = state_reg.irq_enable;
            default:                state_next.rdata = 8'h00;
         endcase
      end

      state_next.irq = events & state_reg.irq_enable[7:3];
   end

   // Error flags raise events as levels; deskew and initial sync raise on loss,
   // and only while alignment is not skipped
   assign events = {state_reg.health[DISPARITY_BIT],
                    state_reg.health[INVALID_CODE_BIT],
                    state_reg.health[UNEXPECTED_K_BIT],
                    ~state_reg.health[DESKEW_BIT] & ~skip_alignment_sequence,
                    ~state_reg.health[INITIAL_SYNC_BIT] & ~skip_alignment_sequence};

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg.health     <= LANE7_LINK_HEALTH_RESET;
         state_reg.irq_enable <= LINK_IRQ_ENABLE_A_RESET;
         state_reg.rdata      <= 8'h00;
         state_reg.rvalid     <= 1'b0;
         state_reg.irq        <= 5'h00;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign cfg_rdata         = state_reg.rdata;
   assign cfg_rvalid        = state_reg.rvalid;
   assign link_event_irq    = state_reg.irq;
   assign lane7_link_health = state_reg.health;
   assign link_irq_enable_a = state_reg.irq_enable;

endmodule

// *** verification/lane_link_partner.sv ***
`timescale 1ns/1ps
module lane_link_partner
   import lane_health_pkg::*;
(
   // Commands in, lane signals out
   input  wire logic               clk_sys,
   input  wire lane_error_counts_t cmd_counts,
   input  wire lane_states_t       cmd_states,
   output lane_error_counts_t      counts = '0,
   output lane_states_t            states = '0
);
   // States move off the edge, since the receiver treats them as asynchronous
   always @(posedge clk_sys) counts <= cmd_counts;
   always @(negedge clk_sys) states <= cmd_states;
endmodule

// *** verification/serial_lane_status_irq_enable_checker.sv ***
`timescale 1ns/1ps
module serial_lane_status_irq_enable_checker
   import lane_health_pkg::*;
(
   // Watched ports
   input wire logic               clk_sys,
   input wire logic               rst_n,
   input wire cfg_req_t           cfg_req,
   input wire logic [7:0]         cfg_rdata,
   input wire logic               cfg_rvalid,
   input wire logic [7:0]         error_threshold,
   input wire lane_error_counts_t lane7_counts,
   input wire logic [4:0]         link_event_irq,
   input wire logic [7:0]         lane7_link_health,
   input wire logic [7:0]         link_irq_enable_a
);
   wire en_hit = cfg_req.addr == LINK_IRQ_ENABLE_A_ADDR;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   disp_flag_a: assert property ($past(rst_n) |-> lane7_link_health[7] ==
      ($past(lane7_counts.disparity) >= $past(error_threshold))) else $error("disparity flag");
   code_flag_a: assert property ($past(rst_n) |-> lane7_link_health[6] ==
      ($past(lane7_counts.invalid_code) >= $past(error_threshold))) else $error("invalid code flag");
   ctrl_flag_a: assert property ($past(rst_n) |-> lane7_link_health[5] ==
      ($past(lane7_counts.unexpected_control) >= $past(error_threshold))) else $error("control flag");
   en_write_a: assert property (cfg_req.wr_en && en_hit |=>
      link_irq_enable_a == ($past(cfg_req.wdata) & IRQ_ENABLE_A_WMASK)) else $error("enable write");
   rd_valid_a: assert property ($past(rst_n) |-> cfg_rvalid == $past(cfg_req.rd_en))
      else $error("read valid");
   en_read_a: assert property (cfg_req.rd_en && en_hit |=> cfg_rdata == $past(link_irq_enable_a))
      else $error("enable read");
   unmapped_rd_a: assert property (cfg_req.rd_en && !en_hit && cfg_req.addr != LANE7_LINK_HEALTH_ADDR
      |=> cfg_rdata == 8'h00) else $error("unmapped read");
   irq_gate_a: assert property ((link_irq_enable_a == 8'h00) [*2] |-> link_event_irq == 5'h00)
      else $error("irq not enabled");
endmodule

// *** verification/tb_serial_lane_status_irq_enable.sv ***
`timescale 1ns/1ps
module tb_serial_lane_status_irq_enable
   import lane_health_pkg::*;
;
   logic               clk_sys = 1'b0;
   logic               rst_n = 1'b0;
   cfg_req_t           req = '0;
   logic [7:0]         thr = 8'h10;
   logic               skip = 1'b0;
   lane_error_counts_t cmd_counts = '0;
   lane_states_t       cmd_states = '0;
   lane_error_counts_t counts;
   lane_states_t       states;
   logic [7:0]         rdata, health, en, en_exp = 8'h00;
   logic               rvalid;
   logic [4:0]         irq;
   int                 n_fail = 0;
   int                 n_compared = 0;
   lane_link_partner i_lane_link_partner (.clk_sys(clk_sys), .cmd_counts(cmd_counts), .cmd_states(cmd_states),
      .counts(counts), .states(states));
   serial_lane_status_irq_enable i_serial_lane_status_irq_enable (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(req),
      .cfg_rdata(rdata), .cfg_rvalid(rvalid), .error_threshold(thr), .skip_alignment_sequence(skip),
      .lane7_counts(counts), .lane7_states_raw(states), .link_event_irq(irq), .lane7_link_health(health),
      .link_irq_enable_a(en));
   initial forever #5 clk_sys = ~clk_sys;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      req.rd_en <= 1'b1;
      req.addr  <= a;
      @(posedge clk_sys);
      req.rd_en <= 1'b0;
      #1;
      cmp({7'h00, rvalid}, 8'h01);
      cmp(rdata, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req.wr_en <= 1'b1;
      req.addr  <= a;
      req.wdata <= d;
      @(posedge clk_sys);
      req.wr_en <= 1'b0;
      if (a == LINK_IRQ_ENABLE_A_ADDR)
         en_exp = d & IRQ_ENABLE_A_WMASK;
   endtask
   // Loss events count only while alignment is not skipped
   task automatic chk(input lane_error_counts_t c, input lane_states_t s, input logic k);
      logic [7:0] h;
      h = {c.disparity >= thr, c.invalid_code >= thr, c.unexpected_control >= thr, s};
      @(posedge clk_sys);
      cmd_counts <= c;
      cmd_states <= s;
      skip       <= k;
      repeat (8) @(posedge clk_sys);
      rd(LANE7_LINK_HEALTH_ADDR, h);
      cmp(health, h);
      cmp({3'h0, irq}, {3'h0, h[7:5] & en_exp[7:5], ~h[4:3] & en_exp[4:3] & {2{~k}}});
      cmp(en, en_exp);
      $display("lane step done at %0t", $time);
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      n_fail++;
      print_verdict();
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(LANE7_LINK_HEALTH_ADDR, 8'h00);
      rd(LINK_IRQ_ENABLE_A_ADDR, 8'h00);
      rd(12'h4b9, 8'h00);
      wr(LINK_IRQ_ENABLE_A_ADDR, 8'hff);
      rd(LINK_IRQ_ENABLE_A_ADDR, 8'hf8);
      wr(LANE7_LINK_HEALTH_ADDR, 8'hff);
      $display("register test done");
      chk(24'h10_0f_11, 5'h1f, 1'b0);
      chk(24'h0f_10_00, 5'h00, 1'b0);
      // Code group sync must still show while alignment is skipped
      chk(24'h0f_10_00, 5'h05, 1'b1);
      wr(LINK_IRQ_ENABLE_A_ADDR, 8'h47);
      chk(24'hff_ff_ff, 5'h15, 1'b0);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      // Counts are still high, so zeros here come from the reset alone
      cmp(health, 8'h00);
      cmp(en, 8'h00);
      cmp({3'h0, irq}, 8'h00);
      rst_n <= 1'b1;
      en_exp = 8'h00;
      rd(LINK_IRQ_ENABLE_A_ADDR, 8'h00);
      $display("reset test done");
      print_verdict();
   end
endmodule
bind serial_lane_status_irq_enable serial_lane_status_irq_enable_checker i_serial_lane_status_irq_enable_checker (
   .clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
   .error_threshold(error_threshold), .lane7_counts(lane7_counts), .link_event_irq(link_event_irq),
   .lane7_link_health(lane7_link_health), .link_irq_enable_a(link_irq_enable_a));
